// ===== logic/pcg_pkg.sv
// Package with the register map, field layouts and types of the clock control block.
`default_nettype none
package pcg_pkg;
    typedef struct packed {
        logic [7:0]  address;
        logic        read;
        logic        write;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } pcg_avs_req_t;

    typedef enum logic [3:0] {
        MS_IDLE = 4'h1,
        MS_ARM  = 4'h2,
        MS_RUN  = 4'h4,
        MS_DONE = 4'h8
    } pcg_meas_t;

    localparam logic [7:0] OFF_SCER = 8'h00;
    localparam logic [7:0] OFF_SCDR = 8'h04;
    localparam logic [7:0] OFF_SCSR = 8'h08;
    localparam logic [7:0] OFF_PCER = 8'h10;
    localparam logic [7:0] OFF_PCDR = 8'h14;
    localparam logic [7:0] OFF_PCSR = 8'h18;
    localparam logic [7:0] OFF_MOR  = 8'h20;
    localparam logic [7:0] OFF_MCFR = 8'h24;
    localparam logic [7:0] OFF_PLLA = 8'h28;
    localparam logic [7:0] OFF_PLLB = 8'h2C;
    localparam logic [7:0] OFF_PCK0 = 8'h40;
    localparam logic [7:0] OFF_PCK1 = 8'h44;
    localparam logic [7:0] OFF_SR   = 8'h68;

    localparam int SC_USB_BIT = 6;
    localparam int SC_PCK_LSB = 8;
    localparam logic [31:0] SC_MASK = 32'h0000_0340;
    localparam int MOR_EN_BIT = 0;
    localparam int MOR_CNT_LSB = 8;
    localparam logic [31:0] MOR_MASK = 32'h0000_FF01;
    localparam int MCFR_RDY_BIT = 16;
    localparam int PLL_DIV_LSB = 0;
    localparam int PLL_CNT_LSB = 8;
    localparam int PLL_MUL_LSB = 16;
    localparam int PLL_USB_LSB = 28;
    localparam logic [31:0] PLL_MASK = 32'h37FF_FFFF;
    localparam int PCK_SRC_LSB = 0;
    localparam int PCK_DIV_LSB = 2;
    localparam logic [31:0] PCK_MASK = 32'h0000_001F;
    localparam int SR_OSC_BIT = 0;
    localparam int SR_LOCK_LSB = 1;
    localparam int SR_PCKRDY_LSB = 8;

    localparam logic [1:0] SRC_SLOW = 2'h0;
    localparam logic [1:0] SRC_MAIN = 2'h1;
    localparam logic [1:0] SRC_PLLA = 2'h2;
    localparam logic [2:0] PCK_DIV_MAX = 3'h6;
    localparam logic [3:0] MEAS_LAST = 4'hF;
    localparam logic [2:0] OSC_PRE_LAST = 3'h7;
endpackage
`default_nettype wire

// ===== logic/pcg_clock_ctrl.sv
// Clock gating, programmable clock outputs, oscillator, frequency meter and PLL lock control.
`timescale 1ns/1ps
`default_nettype none
module pcg_clock_ctrl (
    input  wire logic                I_REF_CLK,
    input  wire logic                I_RST,
    input  wire pcg_pkg::pcg_avs_req_t I_AVS_REQ,
    output logic [31:0]              O_AVS_READDATA,
    output logic                     O_AVS_WAITREQUEST,
    input  wire logic                I_SLOW_TICK,
    input  wire logic                I_MAIN_TICK,
    input  wire logic                I_PLLA_TICK,
    input  wire logic                I_PLLB_TICK,
    output logic [31:0]              O_PERIPH_CLK_EN,
    output logic                     O_USB_CLK_TICK,
    output logic [1:0]               O_PCK_TICK,
    output logic                     O_OSC_EN,
    output logic [1:0]               O_PLL_ON
);
    import pcg_pkg::*;

    function automatic logic [31:0] be_mask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] keep);
        return ((old & ~be_mask(I_AVS_REQ.byteenable))
                | (I_AVS_REQ.writedata & be_mask(I_AVS_REQ.byteenable))) & keep;
    endfunction

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    logic        wait_q;
    logic [31:0] rdata_q;
    logic [31:0] rd_mux;
    wire  [7:0]  addr   = I_AVS_REQ.address;
    wire         do_wr  = I_AVS_REQ.write && !wait_q;
    wire  [31:0] wd     = I_AVS_REQ.writedata & be_mask(I_AVS_REQ.byteenable);
    wire         wr_scer = do_wr && (addr == OFF_SCER);
    wire         wr_scdr = do_wr && (addr == OFF_SCDR);
    wire         wr_pcer = do_wr && (addr == OFF_PCER);
    wire         wr_pcdr = do_wr && (addr == OFF_PCDR);
    wire         wr_mor  = do_wr && (addr == OFF_MOR);
    wire  [1:0]  wr_pll  = {do_wr && (addr == OFF_PLLB), do_wr && (addr == OFF_PLLA)};
    wire  [1:0]  wr_pck  = {do_wr && (addr == OFF_PCK1), do_wr && (addr == OFF_PCK0)};

    // Every access is answered on the second cycle of the request.
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            wait_q  <= !((I_AVS_REQ.read || I_AVS_REQ.write) && wait_q);
            rdata_q <= rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // System and peripheral clock gating
    // ----------------------------------------------------------------
    logic [31:0] sys_q;
    logic [31:0] periph_q;
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            sys_q    <= 32'h0000_0000;
            periph_q <= 32'h0000_0000;
        end else begin
            sys_q    <= (sys_q | (wr_scer ? (wd & SC_MASK) : 32'h0))
                        & ~(wr_scdr ? wd : 32'h0);
            periph_q <= (periph_q | (wr_pcer ? wd : 32'h0))
                        & ~(wr_pcdr ? wd : 32'h0);
        end
    end

    // ----------------------------------------------------------------
    // Main oscillator start-up counter
    // ----------------------------------------------------------------
    logic [31:0] mor_q;
    logic [7:0]  osc_cnt_q;
    logic [2:0]  osc_pre_q;
    logic        osc_pend_q;
    logic        stable_q;
    wire  [31:0] mor_new = merge(mor_q, MOR_MASK);
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            mor_q      <= 32'h0000_0000;
            osc_cnt_q  <= 8'h00;
            osc_pre_q  <= 3'h0;
            osc_pend_q <= 1'b0;
            stable_q   <= 1'b0;
        end else if (wr_mor) begin
            mor_q      <= mor_new;
            stable_q   <= 1'b0;
            osc_pend_q <= mor_new[MOR_EN_BIT];
            osc_cnt_q  <= mor_new[MOR_CNT_LSB +: 8];
            osc_pre_q  <= 3'h0;
        end else if (!mor_q[MOR_EN_BIT]) begin
            stable_q   <= 1'b0;
            osc_pend_q <= 1'b0;
        end else if (osc_pend_q && osc_cnt_q == 8'h00) begin
            stable_q   <= 1'b1;
            osc_pend_q <= 1'b0;
        end else if (osc_pend_q && I_SLOW_TICK) begin
            osc_pre_q <= osc_pre_q + 3'h1;
            if (osc_pre_q == OSC_PRE_LAST) begin
                osc_cnt_q <= osc_cnt_q - 8'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // Main clock frequency measurement
    // ----------------------------------------------------------------
    pcg_meas_t   ms_q;
    logic [3:0]  slow16_q;
    logic [15:0] measured_frequency_q;
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST || !stable_q) begin
            ms_q     <= MS_IDLE;
            slow16_q <= 4'h0;
            measured_frequency_q  <= 16'h0000;
        end else begin
            case (ms_q)
                MS_IDLE: ms_q <= MS_ARM;
                MS_ARM: begin
                    if (I_SLOW_TICK) begin
                        ms_q <= MS_RUN;
                    end
                end
                MS_RUN: begin
                    if (I_MAIN_TICK) begin
                        measured_frequency_q <= measured_frequency_q + 16'h0001;
                    end
                    if (I_SLOW_TICK) begin
                        slow16_q <= slow16_q + 4'h1;
                        if (slow16_q == MEAS_LAST) begin
                            ms_q <= MS_DONE;
                        end
                    end
                end
                default: ms_q <= MS_DONE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // PLL configuration and lock counters
    // ----------------------------------------------------------------
    logic [31:0] pll_q [2];
    logic [1:0]  lock_q;
    logic [1:0]  pll_on_q;
    for (genvar g = 0; g < 2; g++) begin : g_pll
        logic [5:0] cnt_q;
        logic       pend_q;
        wire [31:0] pll_new = merge(pll_q[g], PLL_MASK);
        always_ff @(posedge I_REF_CLK) begin
            if (I_RST) begin
                pll_q[g]    <= 32'h0000_0000;
                pll_on_q[g] <= 1'b0;
                lock_q[g]   <= 1'b0;
                pend_q      <= 1'b0;
                cnt_q       <= 6'h00;
            end else if (wr_pll[g]) begin
                pll_q[g]    <= pll_new;
                pll_on_q[g] <= (pll_new[PLL_DIV_LSB +: 8] != 8'h00)
                               && (pll_new[PLL_MUL_LSB +: 11] != 11'h000);
                lock_q[g]   <= 1'b0;
                pend_q      <= 1'b1;
                cnt_q       <= pll_new[PLL_CNT_LSB +: 6];
            end else if (pend_q && cnt_q == 6'h00) begin
                lock_q[g] <= 1'b1;
                pend_q    <= 1'b0;
            end else if (pend_q && I_SLOW_TICK) begin
                cnt_q <= cnt_q - 6'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // Programmable clock outputs
    // ----------------------------------------------------------------
    logic [31:0] pck_q [2];
    logic [1:0]  pck_out_q;
    logic [1:0]  pck_rdy_q;
    for (genvar g = 0; g < 2; g++) begin : g_pck
        logic [5:0] cnt_q;
        wire  [1:0] sel  = pck_q[g][PCK_SRC_LSB +: 2];
        wire  [2:0] dexp = pck_q[g][PCK_DIV_LSB +: 3];
        wire  [2:0] pclp = (dexp > PCK_DIV_MAX) ? PCK_DIV_MAX : dexp;
        wire  [5:0] top  = 6'((7'h01 << pclp) - 7'h01);
        wire        src  = (sel == SRC_SLOW) ? I_SLOW_TICK :
                           (sel == SRC_MAIN) ? I_MAIN_TICK :
                           (sel == SRC_PLLA) ? I_PLLA_TICK : I_PLLB_TICK;
        wire        en   = sys_q[SC_PCK_LSB + g];
        always_ff @(posedge I_REF_CLK) begin
            if (I_RST) begin
                pck_q[g]     <= 32'h0000_0000;
                cnt_q        <= 6'h00;
                pck_out_q[g] <= 1'b0;
                pck_rdy_q[g] <= 1'b0;
            end else if (wr_pck[g] || !en) begin
                if (wr_pck[g]) begin
                    pck_q[g] <= merge(pck_q[g], PCK_MASK);
                end
                cnt_q        <= 6'h00;
                pck_out_q[g] <= 1'b0;
                pck_rdy_q[g] <= 1'b0;
            end else if (src && cnt_q == top) begin
                cnt_q        <= 6'h00;
                pck_out_q[g] <= 1'b1;
                pck_rdy_q[g] <= 1'b1;
            end else begin
                cnt_q        <= src ? cnt_q + 6'h01 : cnt_q;
                pck_out_q[g] <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // USB clock divider
    // ----------------------------------------------------------------
    logic [1:0] usb_cnt_q;
    logic       usb_out_q;
    wire  [1:0] usb_sel = pll_q[1][PLL_USB_LSB +: 2];
    wire  [1:0] usb_top = (usb_sel == 2'h0) ? 2'h0 : (usb_sel == 2'h1) ? 2'h1 : 2'h3;
    wire        usb_en  = sys_q[SC_USB_BIT];
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST || !usb_en) begin
            usb_cnt_q <= 2'h0;
            usb_out_q <= 1'b0;
        end else if (I_PLLB_TICK) begin
            usb_cnt_q <= (usb_cnt_q == usb_top) ? 2'h0 : usb_cnt_q + 2'h1;
            usb_out_q <= (usb_cnt_q == usb_top);
        end else begin
            usb_out_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Read decode
    // ----------------------------------------------------------------
    always_comb begin
        if (addr == OFF_SCSR) begin
            rd_mux = sys_q;
        end else if (addr == OFF_PCSR) begin
            rd_mux = periph_q;
        end else if (addr == OFF_MOR) begin
            rd_mux = mor_q;
        end else if (addr == OFF_MCFR) begin
            rd_mux = {15'h0, ms_q == MS_DONE, measured_frequency_q};
        end else if (addr == OFF_PLLA) begin
            rd_mux = pll_q[0];
        end else if (addr == OFF_PLLB) begin
            rd_mux = pll_q[1];
        end else if (addr == OFF_PCK0) begin
            rd_mux = pck_q[0];
        end else if (addr == OFF_PCK1) begin
            rd_mux = pck_q[1];
        end else if (addr == OFF_SR) begin
            rd_mux = {22'h0, pck_rdy_q, 5'h0, lock_q, stable_q};
        end else begin
            rd_mux = 32'h0000_0000;
        end
    end

    assign O_AVS_READDATA    = rdata_q;
    assign O_AVS_WAITREQUEST = wait_q;
    assign O_PERIPH_CLK_EN   = periph_q;
    assign O_USB_CLK_TICK    = usb_out_q;
    assign O_PCK_TICK        = pck_out_q;
    assign O_OSC_EN          = mor_q[MOR_EN_BIT];
    assign O_PLL_ON          = pll_on_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);

    a_bus_answer_one: assert property ((I_AVS_REQ.read || I_AVS_REQ.write) && wait_q
        |=> !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST)
        else $error("bus answer not one cycle");
    a_periph_enable: assert property (wr_pcer && !wr_pcdr
        |=> (O_PERIPH_CLK_EN & $past(wd)) == $past(wd))
        else $error("peripheral enable lost");
    a_periph_stop: assert property (wr_pcdr |=> (O_PERIPH_CLK_EN & $past(wd)) == 32'h0)
        else $error("peripheral clock not stopped");
    a_reset_off: assert property ($fell(I_RST) |-> O_PERIPH_CLK_EN == 32'h0)
        else $error("peripheral clock on after reset");
    a_usb_gate: assert property (O_USB_CLK_TICK |-> $past(I_PLLB_TICK) && $past(usb_en))
        else $error("usb tick without source");
    a_usb_enable: assert property (wr_scer && wd[SC_USB_BIT] && !wr_scdr |=> usb_en)
        else $error("usb clock not enabled");
    a_lock_clear: assert property (wr_pll[0] && wd[PLL_CNT_LSB +: 6] != 6'h00
        |=> !lock_q[0] ##1 !lock_q[0])
        else $error("lock not cleared");
    a_lock_time: assert property (wr_pll[1] && wd[PLL_CNT_LSB +: 6] == 6'h00
        |=> ##1 lock_q[1])
        else $error("zero count lock late");
    a_osc_clear: assert property (wr_mor |=> !stable_q)
        else $error("stable not cleared");
    a_div_off: assert property (wr_pll[0] && wd[PLL_DIV_LSB +: 8] == 8'h00 |=> !O_PLL_ON[0])
        else $error("pll on with zero divider");
    a_pck_enabled: assert property (O_PCK_TICK[0] |-> $past(sys_q[SC_PCK_LSB]))
        else $error("pck tick while disabled");

    c_osc_stable: cover property ($rose(stable_q));
    c_meas_done: cover property (ms_q == MS_RUN ##1 ms_q == MS_DONE);
    c_pck_ready: cover property ($rose(pck_rdy_q[1]));
    c_usb_tick: cover property (O_USB_CLK_TICK && usb_sel == 2'h2);
endmodule
`default_nettype wire

// ===== testbench/test_pcg_clock_ctrl.sv
// Self-checking testbench for the clock control block.
`timescale 1ns/1ps
`default_nettype none
module test_pcg_clock_ctrl;
    import pcg_pkg::*;
    logic                ref_clk;
    logic                rst;
    pcg_avs_req_t        avs_req;
    logic [31:0]         avs_readdata;
    logic                avs_waitrequest;
    logic                slow_tick, main_tick, plla_tick, pllb_tick;
    logic [31:0]         periph_en;
    logic                usb_tick;
    logic [1:0]          pck_tick;
    logic                osc_en;
    logic [1:0]          pll_on;
    logic [7:0]          cyc;
    int                  fail_count, check_count, run_cycles;
    int                  usb_n, pck_n [2];
    logic [31:0]         rd;
    int                  base;
    // Tick periods in reference cycles: slow, main, PLL A, PLL B.
    int                  per [4] = '{8, 2, 4, 2};
    logic [2:0]          div_exp [4] = '{3'h0, 3'h2, 3'h1, 3'h3};

    pcg_clock_ctrl i_dut (
        .I_REF_CLK(ref_clk), .I_RST(rst), .I_AVS_REQ(avs_req),
        .O_AVS_READDATA(avs_readdata), .O_AVS_WAITREQUEST(avs_waitrequest),
        .I_SLOW_TICK(slow_tick), .I_MAIN_TICK(main_tick), .I_PLLA_TICK(plla_tick),
        .I_PLLB_TICK(pllb_tick), .O_PERIPH_CLK_EN(periph_en), .O_USB_CLK_TICK(usb_tick),
        .O_PCK_TICK(pck_tick), .O_OSC_EN(osc_en), .O_PLL_ON(pll_on)
    );

    // ----------------------------------------
    // Clock, tick sources and watchdog
    // ----------------------------------------
    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        cyc <= cyc + 8'h01;
        slow_tick <= (cyc[2:0] == 3'h7);
        main_tick <= cyc[0];
        plla_tick <= (cyc[1:0] == 2'h3);
        pllb_tick <= cyc[0];
        usb_n += int'(usb_tick);
        pck_n[0] += int'(pck_tick[0]);
        pck_n[1] += int'(pck_tick[1]);
        run_cycles++;
        if (run_cycles > 20000) begin
            fail_count++;
            complete_run();
        end
    end

    // ----------------------------------------
    // Bus tasks and comparisons
    // ----------------------------------------
    task automatic bus_op(input logic [7:0] a, input logic wr, input logic [31:0] wd);
        @(posedge ref_clk);
        avs_req.address <= a;
        avs_req.write <= wr;
        avs_req.read <= ~wr;
        avs_req.writedata <= wd;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_req.write <= 1'b0;
        avs_req.read <= 1'b0;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus_op(a, 1'b0, 32'h0000_0000);
        check($sformatf("reg %h", a), e, rd & m);
    endtask

    task automatic near(input string what, input int exp, input int got);
        check_count++;
        if (got < exp - 2 || got > exp + 2) begin
            fail_count++;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("Checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        avs_req = '0;
        avs_req.byteenable = 4'hF;
        cyc = 8'h00;
        {slow_tick, main_tick, plla_tick, pllb_tick} = 4'h0;
        rst = 1'b1;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1 check("periph_en", 32'h0, periph_en);
        rd_chk(OFF_PCSR, 32'hFFFF_FFFF, 32'h0);
        rd_chk(OFF_SCSR, 32'hFFFF_FFFF, 32'h0);
        rd_chk(OFF_PLLA, 32'h0000_00FF, 32'h0);
        check("pll_on", 32'h0, 32'(pll_on));
        rd_chk(8'hFC, 32'hFFFF_FFFF, 32'h0);
        bus_op(OFF_PCER, 1'b1, 32'h0000_0110);
        #1 check("periph_en", 32'h0000_0110, periph_en);
        rd_chk(OFF_PCSR, 32'hFFFF_FFFF, 32'h0000_0110);
        bus_op(OFF_PCDR, 1'b1, 32'h0000_0010);
        #1 check("periph_en", 32'h0000_0100, periph_en);
        bus_op(OFF_PCER, 1'b1, 32'hFFFF_FFFF);
        #1 check("periph_en", 32'hFFFF_FFFF, periph_en);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        #1 check("periph_en", 32'h0, periph_en);
        bus_op(OFF_SCER, 1'b1, SC_MASK);
        rd_chk(OFF_SCSR, SC_MASK, SC_MASK);
        bus_op(OFF_SCDR, 1'b1, 32'h0000_0040);
        rd_chk(OFF_SCSR, SC_MASK, 32'h0000_0300);
        bus_op(OFF_SCDR, 1'b1, 32'h0000_0300);
        rd_chk(OFF_SCSR, SC_MASK, 32'h0);
        bus_op(OFF_PLLA, 1'b1, 32'h2003_0600);
        #1 check("pll_on", 32'h0, 32'(pll_on));
        // First PLL: six slow ticks of lock count.
        bus_op(OFF_PLLA, 1'b1, 32'h2003_0605);
        rd_chk(OFF_SR, 32'h0000_0002, 32'h0);
        repeat (20) @(posedge ref_clk);
        rd_chk(OFF_SR, 32'h0000_0002, 32'h0);
        repeat (40) @(posedge ref_clk);
        rd_chk(OFF_SR, 32'h0000_0002, 32'h0000_0002);
        rd_chk(OFF_PLLA, PLL_MASK, 32'h2003_0605);
        check("pll_on", 32'h1, 32'(pll_on));
        // Second PLL: eight slow ticks of lock count, every USB divider.
        for (int d = 0; d < 3; d++) begin
            bus_op(OFF_PLLB, 1'b1, 32'h0004_0805 | (32'(d) << PLL_USB_LSB));
            rd_chk(OFF_SR, 32'h0000_0004, 32'h0);
            repeat (90) @(posedge ref_clk);
            rd_chk(OFF_SR, 32'h0000_0004, 32'h0000_0004);
            if (d == 0) bus_op(OFF_SCER, 1'b1, 32'h0000_0040);
            base = usb_n;
            repeat (320) @(posedge ref_clk);
            near("usb ticks", 160 >> d, usb_n - base);
        end
        bus_op(OFF_PLLB, 1'b1, 32'h0000_0805);
        #1 check("pll_on", 32'h1, 32'(pll_on));
        bus_op(OFF_PLLB, 1'b1, 32'h0004_0800);
        #1 check("pll_on", 32'h1, 32'(pll_on));
        bus_op(OFF_PLLB, 1'b1, 32'h0004_0005);
        #1 check("pll_on", 32'h3, 32'(pll_on));
        rd_chk(OFF_SR, 32'h0000_0004, 32'h0000_0004);
        // Programmable outputs over every source.
        for (int k = 0; k < 2; k++) begin
            for (int s = 0; s < 4; s++) begin
                bus_op(OFF_SCDR, 1'b1, 32'h0000_0100 << k);
                rd_chk(OFF_SR, 32'h0000_0100 << k, 32'h0);
                bus_op(k ? OFF_PCK1 : OFF_PCK0, 1'b1, 32'(s) | (32'(div_exp[s]) << 2));
                rd_chk(k ? OFF_PCK1 : OFF_PCK0, PCK_MASK, 32'(s) | (32'(div_exp[s]) << 2));
                bus_op(OFF_SCER, 1'b1, 32'h0000_0100 << k);
                repeat (64) @(posedge ref_clk);
                rd_chk(OFF_SR, 32'h0000_0100 << k, 32'h0000_0100 << k);
                base = pck_n[k];
                repeat (512) @(posedge ref_clk);
                near("pck ticks", 512 / (per[s] << div_exp[s]), pck_n[k] - base);
            end
        end
        rd_chk(OFF_SCSR, SC_MASK, SC_MASK);
        // Oscillator start-up of three counts, then the frequency meter.
        bus_op(OFF_MOR, 1'b1, 32'h0000_0301);
        #1 check("osc_en", 32'h1, 32'(osc_en));
        repeat (120) @(posedge ref_clk);
        rd_chk(OFF_SR, 32'h0000_0001, 32'h0);
        repeat (90) @(posedge ref_clk);
        rd_chk(OFF_SR, 32'h0000_0001, 32'h0000_0001);
        for (int i = 0; i < 100 && rd[MCFR_RDY_BIT] !== 1'b1; i++) bus_op(OFF_MCFR, 1'b0, 32'h0);
        check("meas done", 32'h1, 32'(rd[MCFR_RDY_BIT]));
        near("main count", 64, int'(rd[15:0]));
        bus_op(OFF_MOR, 1'b1, 32'h0000_0300);
        rd_chk(OFF_SR, 32'h0000_0001, 32'h0);
        complete_run();
    end
endmodule
`default_nettype wire
